// ==== logic/gdmd_pkg.sv ====
// Package for the gate drive PWM mode decoder: constants, modes and carrier types
`default_nettype none
package gdmd_pkg;

  // Register map, APB byte addresses
  localparam logic [11:0] GDMD_CTRL_OFS = 12'h000;
  localparam logic [11:0] GDMD_STAT_OFS = 12'h004;

  // Control register fields
  localparam int GDMD_CTRL_MODE_LSB = 0;
  localparam int GDMD_CTRL_ASYNC_BIT = 3;
  localparam int GDMD_CTRL_STOP_BIT = 4;
  localparam logic [2:0] GDMD_MODE_RST = 3'h0;
  localparam logic GDMD_ASYNC_RST = 1'h0;
  localparam logic GDMD_STOP_RST = 1'h0;

  // Status register fields
  localparam int GDMD_STAT_MODE_LSB = 0;
  localparam int GDMD_STAT_GH_LSB = 3;
  localparam int GDMD_STAT_GL_LSB = 6;
  localparam int GDMD_STAT_HIN_LSB = 9;
  localparam int GDMD_STAT_LIN_LSB = 12;
  localparam int GDMD_STAT_VAR_BIT = 15;

  // Dead time, counted in core clock cycles
  localparam int GDMD_CNT_W = 8;
  localparam int GDMD_DEAD_CYCLES_DFLT = 5;

  // Control modes
  typedef enum logic [2:0] {
    GDMD_MODE_SIX = 3'h0,
    GDMD_MODE_THREE = 3'h1,
    GDMD_MODE_SINGLE = 3'h2,
    GDMD_MODE_HB = 3'h3,
    GDMD_MODE_ABHB_CFET = 3'h4,
    GDMD_MODE_BCHB_AFET = 3'h5,
    GDMD_MODE_AHB_BCFET = 3'h6,
    GDMD_MODE_FET = 3'h7
  } gdmd_mode_t;

  // Synchroniser stages for the six phase inputs and the three strap bits
  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] flt;
  } gdmd_sync_t;

  // Per-phase gate state
  typedef struct packed {
    logic gh;
    logic gl;
    logic [GDMD_CNT_W-1:0] cnt;
  } gdmd_phase_t;

  // Whole state of the decoder
  typedef struct packed {
    gdmd_sync_t sync;
    gdmd_phase_t [2:0] ph;
    logic [2:0] mode;
    logic async_rect;
    logic stop_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gdmd_state_t;

endpackage : gdmd_pkg
`default_nettype wire

// ==== logic/gdmd_top.sv ====
// Three-phase gate drive input decoder with dead time and APB control registers
//
// Function
// - Mode 011 all phases half-bridge, 111 all phases independent FET.
// - 100: A,B half-bridge C FET; 101: B,C half-bridge A FET; 110: A half-bridge.
// - Strapped variant offers seven modes, never mode 100; serial variant all eight.
// - Six-input: only high gives high gate, only low gives low gate.
// - Six-input: both inputs high keeps both gates of that phase off.
// - Three-input with low input 1: high input picks high or low gate.
// - Three-input: low input 0 forces both gates off.
// - Single-PWM: phase A high input sets frequency and duty of driven phase.
// - Single-PWM: A low, B high, B low form Hall A,B,C state code.
// - Codes: 000 stop, 111 align, 110 B-C, 100 A-C, 101 A-B, 001 C-B, 011 C-A, 010 B-A.
// - Source high gate follows PWM, sink low gate on; align sources A, sinks B,C.
// - Default synchronous rectification: source low gate gets inverted PWM.
// - Control bit selects asynchronous rectification, low gate stays off.
// - Phase C high input reverses direction by complementing Hall code, not stop/align.
// - Phase C low input low brakes: all high gates off, low gates on.
// - Control bit selects stop behaviour: brake or coast.
// - Half-bridge phases get dead time so both transistors never conduct together.
// - Half-bridge: low 0 turns both off; low 1 lets high pick the gate.
// - Independent FET: each input drives its own gate, both may be on.
// - FET phases in mixed modes bypass dead time.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module gdmd_top
  import gdmd_pkg::*;
#(
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter int DEAD_CYCLES = GDMD_DEAD_CYCLES_DFLT
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [2:0] I_PHASE_HIGH_INPUT,
  input wire logic [2:0] I_PHASE_LOW_INPUT,
  input wire logic [2:0] I_MODE_STRAP,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [2:0] O_HIGH_SIDE_GATE_OUT,
  output logic [2:0] O_LOW_SIDE_GATE_OUT
);

  localparam logic [GDMD_CNT_W-1:0] DEAD_LOAD = GDMD_CNT_W'(DEAD_CYCLES);

  gdmd_state_t st_r;
  gdmd_state_t st_nxt;

  // Filtered view of the phase pins
  logic [2:0] phase_high_input;
  logic [2:0] phase_low_input;

  // Decoded requests, before dead time
  logic [2:0] req_h;
  logic [2:0] req_l;
  logic [2:0] fet_mask;
  logic [2:0] eff_mode;
  logic mode_change;

  // Pin roles in single-PWM block commutation
  logic pwm_input_phase_a;
  logic direction_input;
  logic brake_input_n;
  logic [2:0] hall_code;
  logic [2:0] src_onehot;
  logic [2:0] sink_mask;

  // Register bus decode and status view
  logic bus_access;
  logic addr_ctrl;
  logic addr_stat;
  logic [31:0] stat_word;

  // Filtered inputs give the decoder its view of the pins
  assign phase_high_input = st_r.sync.flt[2:0];
  assign phase_low_input = st_r.sync.flt[5:3];
  assign pwm_input_phase_a = phase_high_input[0];
  assign direction_input = phase_high_input[2];
  assign brake_input_n = phase_low_input[2];
  // Hall A, B, C from A low, B high, B low
  assign hall_code = {phase_low_input[0], phase_high_input[1], phase_low_input[1]};

  // Mode source: control register on the serial variant, strap pins otherwise
  always_comb begin
    if (SERIAL_VARIANT) begin
      eff_mode = st_r.mode;
    end else begin
      // Strap pins pass the same three-stage filter as the phase inputs
      eff_mode = st_r.sync.flt[8:6];
    end
  end

  // Commutation table, keyed by the direction-corrected Hall code
  always_comb begin
    logic [2:0] code;
    code = hall_code;
    src_onehot = 3'h0;
    sink_mask = 3'h0;
    // Reverse direction maps to the complement; stop and align are fixed points
    if (direction_input && code != 3'h0 && code != 3'h7) begin
      code = ~hall_code;
    end
    // Codes outside the table, stop included, leave both masks clear
    case (code)
      3'h7: begin
        src_onehot = 3'h1;
        sink_mask = 3'h6;
      end
      3'h6: begin
        src_onehot = 3'h2;
        sink_mask = 3'h4;
      end
      3'h4: begin
        src_onehot = 3'h1;
        sink_mask = 3'h4;
      end
      3'h5: begin
        src_onehot = 3'h1;
        sink_mask = 3'h2;
      end
      3'h1: begin
        src_onehot = 3'h4;
        sink_mask = 3'h2;
      end
      3'h3: begin
        src_onehot = 3'h4;
        sink_mask = 3'h1;
      end
      3'h2: begin
        src_onehot = 3'h2;
        sink_mask = 3'h1;
      end
      default: begin
        src_onehot = 3'h0;
        sink_mask = 3'h0;
      end
    endcase
  end

  // Mode decode into per-phase gate requests and dead-time bypass mask
  always_comb begin
    req_h = 3'h0;
    req_l = 3'h0;
    fet_mask = 3'h0;
    case (eff_mode)
      GDMD_MODE_SIX: begin
        req_h = phase_high_input & ~phase_low_input;
        req_l = phase_low_input & ~phase_high_input;
      end
      GDMD_MODE_THREE: begin
        req_h = phase_low_input & phase_high_input;
        req_l = phase_low_input & ~phase_high_input;
      end
      GDMD_MODE_SINGLE: begin
        // Brake outranks every other input, the stop code included
        if (!brake_input_n) begin
          req_h = 3'h0;
          req_l = 3'h7;
        end else if (hall_code == 3'h0) begin
          req_l = st_r.stop_sel ? 3'h7 : 3'h0;
        end else begin
          req_h = pwm_input_phase_a ? src_onehot : 3'h0;
          req_l = sink_mask;
          // Synchronous rectification turns the source low gate on in the PWM gap
          if (!st_r.async_rect && !pwm_input_phase_a) begin
            req_l = sink_mask | src_onehot;
          end
        end
      end
      GDMD_MODE_ABHB_CFET, GDMD_MODE_BCHB_AFET, GDMD_MODE_AHB_BCFET, GDMD_MODE_HB,
      GDMD_MODE_FET: begin
        case (eff_mode)
          GDMD_MODE_ABHB_CFET: begin
            fet_mask = 3'h4;
          end
          GDMD_MODE_BCHB_AFET: begin
            fet_mask = 3'h1;
          end
          GDMD_MODE_AHB_BCFET: begin
            fet_mask = 3'h6;
          end
          GDMD_MODE_FET: begin
            fet_mask = 3'h7;
          end
          default: begin
            fet_mask = 3'h0;
          end
        endcase
        req_h = (fet_mask & phase_high_input) |
                (~fet_mask & phase_low_input & phase_high_input);
        req_l = (fet_mask & phase_low_input) |
                (~fet_mask & phase_low_input & ~phase_high_input);
        // Strapped part has no 100 setting: that strap value keeps all gates off
        if (!SERIAL_VARIANT && eff_mode == GDMD_MODE_ABHB_CFET) begin
          req_h = 3'h0;
          req_l = 3'h0;
          fet_mask = 3'h0;
        end
      end
      default: begin
        req_h = 3'h0;
        req_l = 3'h0;
      end
    endcase
  end

  // APB decode
  assign bus_access = I_PSEL && I_PENABLE;
  assign addr_ctrl = (I_PADDR == GDMD_CTRL_OFS);
  assign addr_stat = (I_PADDR == GDMD_STAT_OFS);

  // Status word shows live mode, gates and filtered inputs
  always_comb begin
    stat_word = 32'h0;
    // Gates shown are the registered outputs, one cycle behind the decoder
    stat_word[GDMD_STAT_MODE_LSB +: 3] = eff_mode;
    stat_word[GDMD_STAT_GH_LSB +: 3] = O_HIGH_SIDE_GATE_OUT;
    stat_word[GDMD_STAT_GL_LSB +: 3] = O_LOW_SIDE_GATE_OUT;
    stat_word[GDMD_STAT_HIN_LSB +: 3] = phase_high_input;
    stat_word[GDMD_STAT_LIN_LSB +: 3] = phase_low_input;
    stat_word[GDMD_STAT_VAR_BIT] = SERIAL_VARIANT;
  end

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;

    // Three-stage synchroniser; value moves only when stages two and three agree
    st_nxt.sync.s1 = {I_MODE_STRAP, I_PHASE_LOW_INPUT, I_PHASE_HIGH_INPUT};
    st_nxt.sync.s2 = st_r.sync.s1;
    st_nxt.sync.s3 = st_r.sync.s2;
    for (int b = 0; b < 9; b++) begin
      if (st_r.sync.s2[b] == st_r.sync.s3[b]) begin
        st_nxt.sync.flt[b] = st_r.sync.s3[b];
      end
    end

    // Per-phase gate stage with dead time on half-bridge phases
    for (int p = 0; p < 3; p++) begin
      if (fet_mask[p]) begin
        // Direct drive; the controller owns shoot-through timing here
        st_nxt.ph[p].gh = req_h[p];
        st_nxt.ph[p].gl = req_l[p];
        st_nxt.ph[p].cnt = '0;
      end else if ((st_r.ph[p].gh && !req_h[p]) || (st_r.ph[p].gl && !req_l[p])) begin
        // Turn-off is immediate; the dead window starts here
        st_nxt.ph[p].gh = st_r.ph[p].gh && req_h[p];
        st_nxt.ph[p].gl = st_r.ph[p].gl && req_l[p];
        st_nxt.ph[p].cnt = DEAD_LOAD;
      end else if (st_r.ph[p].cnt != '0) begin
        // Dead window running: gates stay where turn-off left them
        st_nxt.ph[p].cnt = st_r.ph[p].cnt - 1'b1;
      end else if (!st_r.ph[p].gh && !st_r.ph[p].gl) begin
        // Both requests set cannot occur in a half-bridge phase; high wins anyway
        st_nxt.ph[p].gh = req_h[p];
        st_nxt.ph[p].gl = req_l[p] && !req_h[p];
      end
    end

    // Last guard for half-bridge phases: should both ever be set, the low gate yields
    for (int p = 0; p < 3; p++) begin
      if (!fet_mask[p] && st_nxt.ph[p].gh && st_nxt.ph[p].gl) begin
        st_nxt.ph[p].gl = 1'b0;
      end
    end

    // APB slave: one wait state, answer pulses for one cycle
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (bus_access && !st_r.pready) begin
      // Read data is captured with ready so both leave flops in the same cycle
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !(addr_ctrl || addr_stat);
      st_nxt.prdata = 32'h0;
      if (!I_PWRITE && addr_ctrl) begin
        st_nxt.prdata[GDMD_CTRL_MODE_LSB +: 3] = st_r.mode;
        st_nxt.prdata[GDMD_CTRL_ASYNC_BIT] = st_r.async_rect;
        st_nxt.prdata[GDMD_CTRL_STOP_BIT] = st_r.stop_sel;
      end else if (!I_PWRITE && addr_stat) begin
        st_nxt.prdata = stat_word;
      end
    end
    // Writes land at the completing edge; every control register write is ignored when strapped
    if (bus_access && st_r.pready && I_PWRITE && addr_ctrl && SERIAL_VARIANT) begin
      st_nxt.mode = I_PWDATA[GDMD_CTRL_MODE_LSB +: 3];
      st_nxt.async_rect = I_PWDATA[GDMD_CTRL_ASYNC_BIT];
      st_nxt.stop_sel = I_PWDATA[GDMD_CTRL_STOP_BIT];
    end

    // A mode change drops every gate and restarts the dead window: a phase that leaves
    // independent FET control with both gates on never carries that into a half-bridge
    if (SERIAL_VARIANT) begin
      mode_change = (st_nxt.mode != st_r.mode);
    end else begin
      mode_change = (st_nxt.sync.flt[8:6] != st_r.sync.flt[8:6]);
    end
    if (mode_change) begin
      for (int p = 0; p < 3; p++) begin
        st_nxt.ph[p].gh = 1'b0;
        st_nxt.ph[p].gl = 1'b0;
        st_nxt.ph[p].cnt = DEAD_LOAD;
      end
    end
  end

  // State register
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      // Comes up in six-input mode, coast stop, synchronous rectification
      st_r <= '0;
      st_r.mode <= GDMD_MODE_RST;
      st_r.async_rect <= GDMD_ASYNC_RST;
      st_r.stop_sel <= GDMD_STOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      O_HIGH_SIDE_GATE_OUT[p] = st_r.ph[p].gh;
      O_LOW_SIDE_GATE_OUT[p] = st_r.ph[p].gl;
    end
  end
  assign O_PRDATA = st_r.prdata;
  assign O_PREADY = st_r.pready;
  assign O_PSLVERR = st_r.pslverr;

endmodule : gdmd_top
`default_nettype wire

// ==== tb/gdmd_properties.sv ====
// Port checker for the gate drive decoder, bound to its top module
`default_nettype none
module gdmd_properties
  import gdmd_pkg::*;
#(
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter int DEAD_CYCLES = GDMD_DEAD_CYCLES_DFLT
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [2:0] I_PHASE_HIGH_INPUT,
  input wire logic [2:0] I_PHASE_LOW_INPUT,
  input wire logic [2:0] I_MODE_STRAP,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [2:0] O_HIGH_SIDE_GATE_OUT,
  input wire logic [2:0] O_LOW_SIDE_GATE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_r;
  wire [2:0] h = I_PHASE_HIGH_INPUT;
  wire [2:0] l = I_PHASE_LOW_INPUT;
  wire [2:0] gh = O_HIGH_SIDE_GATE_OUT;
  wire [2:0] gl = O_LOW_SIDE_GATE_OUT;
  // Mirror of the mode field; the checker cannot see the register itself
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_r <= 3'h0;
    end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == GDMD_CTRL_OFS) begin
      mode_r <= I_PWDATA[2:0];
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  // Bus answers after exactly one wait state, ready is a single pulse
  AST_APB_WAIT: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("ready late");
  AST_APB_PULSE: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held");
  AST_APB_ERR: assert property (I_PSEL && I_PENABLE && O_PREADY |->
    O_PSLVERR == (I_PADDR != GDMD_CTRL_OFS && I_PADDR != GDMD_STAT_OFS))
    else $error("error flag wrong");
  AST_RD_ZERO: assert property (O_PREADY && O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
    else $error("refused read data");
  AST_HB_EXCL: assert property (mode_r < 3'h4 |-> (gh & gl) == 3'h0)
    else $error("both gates on");
  AST_DEAD: assert property (mode_r < 3'h4 && $fell(gh[0]) |-> !gl[0] [*2])
    else $error("no dead time");
  AST_SIX_BOTH: assert property ((mode_r == 3'h0 && h[0] && l[0]) [*7] |-> !gh[0] && !gl[0])
    else $error("six input both high");
  AST_THREE_OFF: assert property ((mode_r == 3'h1 && !l[0]) [*7] |-> !gh[0] && !gl[0])
    else $error("three input float");
  AST_FET_BOTH: assert property ((mode_r == 3'h7 && (h & l) == 3'h7) [*8] |->
    gh == 3'h7 && gl == 3'h7)
    else $error("fet mode both");
  AST_BRAKE: assert property ((mode_r == 3'h2 && !l[2]) [*8] |-> gh == 3'h0 && gl == 3'h7)
    else $error("brake");
  cover property (O_PREADY && O_PSLVERR);
  cover property (mode_r == 3'h2 && gl == 3'h7);
  cover property (gh == 3'h7 && gl == 3'h7);
endmodule : gdmd_properties
bind gdmd_top gdmd_properties #(.SERIAL_VARIANT(SERIAL_VARIANT), .DEAD_CYCLES(DEAD_CYCLES))
  props_u (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .I_PHASE_HIGH_INPUT(I_PHASE_HIGH_INPUT), .I_PHASE_LOW_INPUT(I_PHASE_LOW_INPUT),
    .I_MODE_STRAP(I_MODE_STRAP), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_HIGH_SIDE_GATE_OUT(O_HIGH_SIDE_GATE_OUT),
    .O_LOW_SIDE_GATE_OUT(O_LOW_SIDE_GATE_OUT));
`default_nettype wire

// ==== tb/gdmd_mcu_model.sv ====
// Controller model that drives the six phase inputs
`default_nettype none
module gdmd_mcu_model (
  input wire logic i_clk,
  input wire logic i_quiet,
  input wire logic [2:0] i_hi_cmd,
  input wire logic [2:0] i_lo_cmd,
  output var logic [2:0] o_hi = 3'h0,
  output var logic [2:0] o_lo = 3'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins move just after the edge; quiet parks all inputs low for mode changes
  always @(posedge i_clk) begin
    o_hi <= i_quiet ? 3'h0 : i_hi_cmd;
    o_lo <= i_quiet ? 3'h0 : i_lo_cmd;
  end
endmodule : gdmd_mcu_model
`default_nettype wire

// ==== tb/tb_gdmd_top.sv ====
// Self-checking bench for the gate drive decoder
`default_nettype none
module tb_gdmd_top import gdmd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, quiet = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] hic = 3'h0, loc = 3'h0, strap = 3'h0, hi, lo, gh, gl;
  logic pready, pslverr;
  int err_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  gdmd_mcu_model mcu_u (.i_clk(clk), .i_quiet(quiet), .i_hi_cmd(hic), .i_lo_cmd(loc),
    .o_hi(hi), .o_lo(lo));
  // Short dead time keeps the settle windows small
  gdmd_top #(.DEAD_CYCLES(1)) dut_u (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PHASE_HIGH_INPUT(hi), .I_PHASE_LOW_INPUT(lo), .I_MODE_STRAP(strap),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_HIGH_SIDE_GATE_OUT(gh), .O_LOW_SIDE_GATE_OUT(gl));
  task automatic print_verdict;
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One transfer; waits an edge first so back-to-back calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) begin
      chk("pready", 32'h1, 32'h0);
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic set_mode(input logic [4:0] c);
    logic [31:0] r;
    logic e;
    quiet <= 1'b1;
    repeat (12) @(posedge clk);
    apb(1'b1, GDMD_CTRL_OFS, {27'h0, c}, r, e);
    quiet <= 1'b0;
  endtask : set_mode
  // Settle window covers sync latency plus dead time
  task automatic drive(input logic [2:0] h, l, eh, el);
    hic <= h;
    loc <= l;
    repeat (20) @(posedge clk);
    chk("high gates", {29'h0, eh}, {29'h0, gh});
    chk("low gates", {29'h0, el}, {29'h0, gl});
  endtask : drive
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    // Straps at the one value the register variant alone offers; they must not win
    strap <= 3'h4;
    apb(1'b0, GDMD_CTRL_OFS, 32'h0, r, e);
    chk("ctrl reset", 32'h0, r);
    apb(1'b1, 12'h008, 32'h1f, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
    apb(1'b0, GDMD_STAT_OFS, 32'h0, r, e);
    chk("variant flag", 32'h1, {31'h0, r[GDMD_STAT_VAR_BIT]});
    apb(1'b1, GDMD_CTRL_OFS, 32'h1b, r, e);
    apb(1'b0, GDMD_CTRL_OFS, 32'h0, r, e);
    chk("ctrl readback", 32'h1b, r);
    apb(1'b0, GDMD_STAT_OFS, 32'h0, r, e);
    chk("status mode", 32'h3, {29'h0, r[2:0]});
  endtask : t_regs
  task automatic t_six;
    set_mode(5'h00);
    drive(3'h3, 3'h5, 3'h2, 3'h4);
    drive(3'h0, 3'h0, 3'h0, 3'h0);
  endtask : t_six
  task automatic t_modes;
    logic [2:0] f, h, l;
    logic [5:0] v[2] = '{6'h3f, 6'h2e};
    for (int m = 1; m < 8; m++) begin
      f = m == 7 ? 3'h7 : m == 4 ? 3'h4 : m == 5 ? 3'h1 : m == 6 ? 3'h6 : 3'h0;
      if (m != 2) begin
        set_mode(m[4:0]);
        foreach (v[k]) begin
          h = v[k][5:3];
          l = v[k][2:0];
          drive(h, l, h & (f | l), l & (f | ~h));
        end
      end
    end
  endtask : t_modes
  // Table rows: hall code, sourcing phases, sinking phases
  task automatic t_single;
    logic [8:0] t[7] = '{9'h1ce, 9'h194, 9'h10c, 9'h14a, 9'h062, 9'h0e1, 9'h091};
    logic [8:0] e;
    logic [2:0] c;
    set_mode(5'h02);
    for (int i = 0; i < 14; i++) begin
      e = t[i / 2];
      c = (i % 2 == 1 && e[8:6] != 3'h7) ? ~e[8:6] : e[8:6];
      drive({i[0], c[1], 1'b1}, {1'b1, c[0], c[2]}, e[5:3], e[2:0]);
      drive({i[0], c[1], 1'b0}, {1'b1, c[0], c[2]}, 3'h0, e[5:3] | e[2:0]);
    end
    drive(3'h1, 3'h4, 3'h0, 3'h0);
    drive(3'h1, 3'h0, 3'h0, 3'h7);
    set_mode(5'h1a);
    drive(3'h2, 3'h5, 3'h0, 3'h4);
    drive(3'h0, 3'h4, 3'h0, 3'h7);
  endtask : t_single
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_six();
    t_modes();
    t_single();
    print_verdict();
  end
endmodule : tb_gdmd_top
`default_nettype wire
